// *** hw/fp_compare_convert_unit.sv ***
// compare and convert slice: decode, status flags, result and condition outputs
module fp_compare_convert_unit (
  // clock and reset
  input  logic             clk_sys,
  input  logic             sys_rst,
  // issue from the sequencer
  input  logic             issue_valid,
  input  fp_compare_code_pkg::instr_t instr,
  input  fp_compare_code_pkg::dword_t src_a,
  input  fp_compare_code_pkg::dword_t src_b,
  // configuration and status levels kept elsewhere
  input  logic             impl_64bit,
  input  fp_compare_code_pkg::rnd_t   round_select,
  input  logic             invalid_enable,
  input  logic             inexact_enable,
  input  logic             overflow_flag,
  input  logic             status_clear,
  // results
  output logic             result_valid,
  output logic             illegal_instr,
  output logic             target_write,
  output logic [4:0]       target_index,
  output fp_compare_code_pkg::dword_t target_data,
  output logic             cr_field_write,
  output logic [2:0]       cr_field_index,
  output fp_compare_code_pkg::cc_t    cr_field_value,
  output logic             cr1_write,
  output logic [3:0]       cr1_value,
  // status flags
  output fp_compare_code_pkg::cc_t    fp_compare_code,
  output logic             rounding_increment_flag,
  output logic             inexact_flag,
  output logic             inexact_sticky,
  output logic             signaling_nan_invalid,
  output logic             invalid_convert_flag,
  output logic             exception_summary,
  output logic             enabled_summary,
  output logic             invalid_summary
);
  import fp_compare_code_pkg::*;

  fp_op_if op_bus ();

  fp_compare u_compare (
    .op (op_bus.compare)
  );

  fp_to_int u_to_int (
    .op (op_bus.convert)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  op_kind_t kind;
  logic     is_dword;
  logic     cmp_issue;
  logic     cvt_issue;
  logic     illegal_issue;
  logic     record;

  always_comb begin
    kind = OP_NONE;
    if (instr[PRIM_HI:PRIM_LO] == OPC_PRIMARY) begin
      case (instr[XO_HI:XO_LO])
        XO_CMPU:    kind = OP_CMPU;
        XO_CVT_DW:  kind = (instr[RA_HI:RA_LO] == RA_ZERO) ? OP_CVT_DW : OP_NONE;
        XO_CVT_DWZ: kind = (instr[RA_HI:RA_LO] == RA_ZERO) ? OP_CVT_DWZ : OP_NONE;
        XO_CVT_W:   kind = OP_CVT_W;
        default:    kind = OP_NONE;
      endcase
    end
  end

  assign is_dword      = (kind == OP_CVT_DW) || (kind == OP_CVT_DWZ);
  assign cmp_issue     = issue_valid && (kind == OP_CMPU);
  assign cvt_issue     = issue_valid && ((is_dword && impl_64bit) || (kind == OP_CVT_W));
  // a narrow core traps the doubleword forms and writes nothing
  assign illegal_issue = issue_valid && is_dword && !impl_64bit;
  assign record        = instr[REC_BIT];

  // all three conversion forms share one converter, so they share this path
  assign op_bus.cmp_a    = src_a;
  assign op_bus.cmp_b    = src_b;
  assign op_bus.cvt_src  = src_b;
  assign op_bus.cvt_mode = (kind == OP_CVT_DWZ) ? RND_ZERO : round_select;
  assign op_bus.cvt_word = (kind == OP_CVT_W);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic        valid_reg;
  logic        valid_next;
  logic        illegal_reg;
  logic        illegal_next;
  logic        twr_reg;
  logic        twr_next;
  logic [4:0]  tidx_reg;
  logic [4:0]  tidx_next;
  dword_t      tdata_reg;
  dword_t      tdata_next;
  logic        crw_reg;
  logic        crw_next;
  logic [2:0]  cridx_reg;
  logic [2:0]  cridx_next;
  cc_t         crval_reg;
  cc_t         crval_next;
  logic        cr1w_reg;
  logic        cr1w_next;
  logic [3:0]  cr1val_reg;
  logic [3:0]  cr1val_next;
  cc_t         cc_reg;
  cc_t         cc_next;
  logic        fr_reg;
  logic        fr_next;
  logic        fi_reg;
  logic        fi_next;
  logic        xx_reg;
  logic        xx_next;
  logic        snan_reg;
  logic        snan_next;
  logic        cvi_reg;
  logic        cvi_next;
  logic        fx_reg;
  logic        fx_next;
  logic        fex_reg;
  logic        fex_next;
  logic        vx_reg;
  logic        vx_next;
  logic        snan_set;
  logic        cvi_set;
  logic        xx_set;

  always_comb begin
    snan_set = (cmp_issue && op_bus.cmp_snan) || (cvt_issue && op_bus.cvt_snan);
    cvi_set  = cvt_issue && op_bus.cvt_invalid;
    xx_set   = cvt_issue && op_bus.cvt_inexact;
    // sticky bits: a set in the clearing cycle survives the clear
    snan_next = snan_set || (snan_reg && !status_clear);
    cvi_next  = cvi_set || (cvi_reg && !status_clear);
    xx_next   = xx_set || (xx_reg && !status_clear);
    // summary rises only on a flag going from clear to set
    // a flag cleared in this cycle counts as clear, so set wins here too
    fx_next   = (snan_set && (!snan_reg || status_clear)) || (cvi_set && (!cvi_reg || status_clear)) ||
                (xx_set && (!xx_reg || status_clear)) ||
                (fx_reg && !status_clear);
    vx_next   = snan_next || cvi_next;
    fex_next  = (vx_next && invalid_enable) || (xx_next && inexact_enable);
    // the compare leaves rounding flags alone and never raises cvi
    fr_next   = cvt_issue ? op_bus.cvt_inc : fr_reg;
    fi_next   = cvt_issue ? op_bus.cvt_inexact : fi_reg;
    // conversions leave the code untouched; no result class is kept here
    cc_next   = cmp_issue ? op_bus.cmp_code : cc_reg;
    valid_next   = cmp_issue || cvt_issue || illegal_issue;
    illegal_next = illegal_issue;
    twr_next     = cvt_issue;
    tidx_next    = cvt_issue ? instr[TGT_HI:TGT_LO] : tidx_reg;
    tdata_next   = cvt_issue ? op_bus.cvt_result : tdata_reg;
    crw_next     = cmp_issue;
    cridx_next   = cmp_issue ? instr[CRF_HI:CRF_LO] : cridx_reg;
    crval_next   = cmp_issue ? op_bus.cmp_code : crval_reg;
    cr1w_next    = cvt_issue && record;
    cr1val_next  = cr1w_next ? {fx_next, fex_next, vx_next, overflow_flag} : cr1val_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      valid_reg   <= 1'b0;
      illegal_reg <= 1'b0;
      twr_reg     <= 1'b0;
      tidx_reg    <= 5'h00;
      tdata_reg   <= 64'h0;
      crw_reg     <= 1'b0;
      cridx_reg   <= 3'h0;
      crval_reg   <= 4'h0;
      cr1w_reg    <= 1'b0;
      cr1val_reg  <= 4'h0;
      cc_reg      <= 4'h0;
      fr_reg      <= 1'b0;
      fi_reg      <= 1'b0;
      xx_reg      <= 1'b0;
      snan_reg    <= 1'b0;
      cvi_reg     <= 1'b0;
      fx_reg      <= 1'b0;
      fex_reg     <= 1'b0;
      vx_reg      <= 1'b0;
    end else begin
      valid_reg   <= valid_next;
      illegal_reg <= illegal_next;
      twr_reg     <= twr_next;
      tidx_reg    <= tidx_next;
      tdata_reg   <= tdata_next;
      crw_reg     <= crw_next;
      cridx_reg   <= cridx_next;
      crval_reg   <= crval_next;
      cr1w_reg    <= cr1w_next;
      cr1val_reg  <= cr1val_next;
      cc_reg      <= cc_next;
      fr_reg      <= fr_next;
      fi_reg      <= fi_next;
      xx_reg      <= xx_next;
      snan_reg    <= snan_next;
      cvi_reg     <= cvi_next;
      fx_reg      <= fx_next;
      fex_reg     <= fex_next;
      vx_reg      <= vx_next;
    end
  end

  assign result_valid            = valid_reg;
  assign illegal_instr           = illegal_reg;
  assign target_write            = twr_reg;
  assign target_index            = tidx_reg;
  assign target_data             = tdata_reg;
  assign cr_field_write          = crw_reg;
  assign cr_field_index          = cridx_reg;
  assign cr_field_value          = crval_reg;
  assign cr1_write               = cr1w_reg;
  assign cr1_value               = cr1val_reg;
  assign fp_compare_code         = cc_reg;
  assign rounding_increment_flag = fr_reg;
  assign inexact_flag            = fi_reg;
  assign inexact_sticky          = xx_reg;
  assign signaling_nan_invalid   = snan_reg;
  assign invalid_convert_flag    = cvi_reg;
  assign exception_summary       = fx_reg;
  assign enabled_summary         = fex_reg;
  assign invalid_summary         = vx_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic src_b_pinf;
  logic src_b_ninf;
  logic any_nan;
  assign src_b_pinf = (src_b == 64'h7FF0_0000_0000_0000);
  assign src_b_ninf = (src_b == 64'hFFF0_0000_0000_0000);
  assign any_nan    = ((src_a[62:52] == EXP_ALL_ONES) && (src_a[51:0] != 52'h0)) ||
                      ((src_b[62:52] == EXP_ALL_ONES) && (src_b[51:0] != 52'h0));

  sequence s_cmp;
    cmp_issue;
  endsequence

  sequence s_cmp_answer;
    cr_field_write && (cr_field_value == fp_compare_code);
  endsequence

  a_cmp_field_copy: assert property (s_cmp |=> s_cmp_answer and (cr_field_index == $past(instr[CRF_HI:CRF_LO])))
    else $error("compare code not copied into the selected field");
  a_cmp_nan_unord: assert property (s_cmp and any_nan |=> cr_field_value == CC_UNORD)
    else $error("nan operand did not give unordered");
  a_cmp_snan_flag: assert property (cmp_issue && op_bus.cmp_snan |=> signaling_nan_invalid && exception_summary)
    else $error("signaling nan compare did not set flags");
  a_cmp_no_cvi: assert property (s_cmp and !status_clear |=> $stable(invalid_convert_flag) && !target_write
                                 && $stable(rounding_increment_flag))
    else $error("compare disturbed conversion state");
  a_code_onehot: assert property (cr_field_write |-> $onehot(cr_field_value))
    else $error("compare code not onehot");
  a_dw_pos_sat: assert property (cvt_issue && is_dword && src_b_pinf |=> target_data == DW_POS_MAX
                                 && invalid_convert_flag)
    else $error("doubleword positive saturation wrong");
  a_dw_neg_sat: assert property (cvt_issue && is_dword && src_b_ninf |=> target_data == DW_NEG_MIN)
    else $error("doubleword negative saturation wrong");
  a_trunc_no_inc: assert property (cvt_issue && (kind == OP_CVT_DWZ) |=> !rounding_increment_flag)
    else $error("truncating conversion rounded up");
  a_narrow_illegal: assert property (issue_valid && is_dword && !impl_64bit |=> illegal_instr && !target_write
                                     && result_valid)
    else $error("doubleword form not trapped on narrow core");
  a_word_sat: assert property (cvt_issue && (kind == OP_CVT_W) && src_b_pinf |=> target_data[31:0] == W_POS_MAX
                               && target_data[63:32] == 32'h0)
    else $error("word positive saturation wrong");
  a_record_cr1: assert property (cvt_issue |=> cr1_write == $past(record))
    else $error("field 1 write does not follow record bit");
  a_cr1_value: assert property (cr1_write |-> cr1_value == {exception_summary, enabled_summary,
                                invalid_summary, $past(overflow_flag)})
    else $error("field 1 value does not match summaries");
  a_sticky_hold: assert property (inexact_sticky && !status_clear |=> inexact_sticky ##1 1'b1)
    else $error("sticky inexact dropped without clear");
endmodule

// *** hw/fp_compare_code_pkg.sv ***
// shared constants and types for the compare and convert slice
// What this block does
// - unordered compare sets code, copies to chosen field
// - any nan operand gives unordered code
// - signaling nan operand sets signaling nan flag
// - compare touches code, signaling flag and the summaries it feeds only
// - opcode 63 xo 814: doubleword, status rounding
// - xo 815: doubleword, always toward zero
// - doubleword results saturate to max or min
// - result class field left untouched by conversions
// - set increment and inexact flags from rounding
// - doubleword forms illegal on 32-bit implementation
// - xo 14: word conversion, status rounding
// - word result in low half, high zero
// - word results saturate to max or min
// - word conversion updates the listed status flags
// - record bit copies summaries into field 1
package fp_compare_code_pkg;
  typedef logic [63:0] dword_t;
  typedef logic [31:0] instr_t;
  typedef logic [3:0]  cc_t;
  typedef logic [1:0]  rnd_t;
  typedef enum logic [2:0] {OP_NONE, OP_CMPU, OP_CVT_DW, OP_CVT_DWZ, OP_CVT_W} op_kind_t;
  ////////////////////////////////////////////////////////////////////////////
  // instruction fields, bit 0 of the word is our msb
  localparam int unsigned PRIM_HI = 31;
  localparam int unsigned PRIM_LO = 26;
  localparam int unsigned CRF_HI  = 25;
  localparam int unsigned CRF_LO  = 23;
  localparam int unsigned TGT_HI  = 25;
  localparam int unsigned TGT_LO  = 21;
  localparam int unsigned RA_HI   = 20;
  localparam int unsigned RA_LO   = 16;
  localparam int unsigned XO_HI   = 10;
  localparam int unsigned XO_LO   = 1;
  localparam int unsigned REC_BIT = 0;
  localparam logic [5:0] OPC_PRIMARY = 6'h3F;
  localparam logic [9:0] XO_CMPU     = 10'h000;
  localparam logic [9:0] XO_CVT_DW   = 10'h32E;
  localparam logic [9:0] XO_CVT_DWZ  = 10'h32F;
  localparam logic [9:0] XO_CVT_W    = 10'h00E;
  localparam logic [4:0] RA_ZERO     = 5'h00;
  ////////////////////////////////////////////////////////////////////////////
  // compare code patterns
  localparam cc_t CC_LESS  = 4'h8;
  localparam cc_t CC_GREAT = 4'h4;
  localparam cc_t CC_EQUAL = 4'h2;
  localparam cc_t CC_UNORD = 4'h1;
  // saturation patterns and magnitude limits
  localparam dword_t      DW_POS_MAX = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam dword_t      DW_NEG_MIN = 64'h8000_0000_0000_0000;
  localparam logic [31:0] W_POS_MAX  = 32'h7FFF_FFFF;
  localparam logic [31:0] W_NEG_MIN  = 32'h8000_0000;
  localparam logic [64:0] DW_MAG_POS = 65'h0_7FFF_FFFF_FFFF_FFFF;
  localparam logic [64:0] DW_MAG_NEG = 65'h0_8000_0000_0000_0000;
  localparam logic [64:0] W_MAG_POS  = 65'h0_0000_0000_7FFF_FFFF;
  localparam logic [64:0] W_MAG_NEG  = 65'h0_0000_0000_8000_0000;
  // double format
  localparam logic [10:0]        EXP_ALL_ONES = 11'h7FF;
  localparam logic [10:0]        EXP_ONE      = 11'h001;
  localparam logic signed [12:0] EXP_BIAS     = 13'sh03FF;
  localparam logic signed [12:0] E_MAX        = 13'sh003F;
  localparam logic signed [12:0] E_MIN        = 13'sh1FC0;
  // rounding modes
  localparam rnd_t RND_NEAR = 2'h0;
  localparam rnd_t RND_ZERO = 2'h1;
  localparam rnd_t RND_PINF = 2'h2;
  localparam rnd_t RND_NINF = 2'h3;
endpackage

// *** hw/fp_op_if.sv ***
// operand and result bundle between the slice and its arithmetic leaves
interface fp_op_if;
  import fp_compare_code_pkg::*;
  dword_t cmp_a;
  dword_t cmp_b;
  cc_t    cmp_code;
  logic   cmp_snan;
  dword_t cvt_src;
  rnd_t   cvt_mode;
  logic   cvt_word;
  dword_t cvt_result;
  logic   cvt_inc;
  logic   cvt_inexact;
  logic   cvt_invalid;
  logic   cvt_snan;
  modport compare (input cmp_a, cmp_b, output cmp_code, cmp_snan);
  modport convert (input cvt_src, cvt_mode, cvt_word,
                   output cvt_result, cvt_inc, cvt_inexact, cvt_invalid, cvt_snan);
  modport ctrl    (output cmp_a, cmp_b, cvt_src, cvt_mode, cvt_word,
                   input cmp_code, cmp_snan, cvt_result, cvt_inc, cvt_inexact, cvt_invalid, cvt_snan);
endinterface

// *** hw/fp_compare.sv ***
// unordered double compare, purely combinational
module fp_compare (
  fp_op_if.compare op
);
  import fp_compare_code_pkg::*;
  logic nan_a;
  logic nan_b;
  logic both_zero;
  logic mag_gt;
  always_comb begin
    nan_a     = (op.cmp_a[62:52] == EXP_ALL_ONES) && (op.cmp_a[51:0] != 52'h0);
    nan_b     = (op.cmp_b[62:52] == EXP_ALL_ONES) && (op.cmp_b[51:0] != 52'h0);
    both_zero = (op.cmp_a[62:0] == 63'h0) && (op.cmp_b[62:0] == 63'h0);
    mag_gt    = op.cmp_a[62:0] > op.cmp_b[62:0];
    // quiet bit clear on a nan marks it signaling
    op.cmp_snan = (nan_a && !op.cmp_a[51]) || (nan_b && !op.cmp_b[51]);
    if (nan_a || nan_b) begin
      op.cmp_code = CC_UNORD;
    end else if (both_zero || (op.cmp_a == op.cmp_b)) begin
      // signed zeros compare equal
      op.cmp_code = CC_EQUAL;
    end else if (op.cmp_a[63] != op.cmp_b[63]) begin
      op.cmp_code = op.cmp_a[63] ? CC_LESS : CC_GREAT;
    end else begin
      op.cmp_code = (op.cmp_a[63] ^ mag_gt) ? CC_GREAT : CC_LESS;
    end
  end
endmodule

// *** hw/fp_to_int.sv ***
// double to signed integer conversion, word or doubleword, combinational
module fp_to_int (
  fp_op_if.convert op
);
  import fp_compare_code_pkg::*;
  logic               sgn;
  logic [10:0]        exp_eff;
  logic [52:0]        mant;
  logic signed [12:0] uexp;
  logic [12:0]        neg_exp;
  logic               is_nan;
  logic               big;
  logic               tiny;
  logic [191:0]       fixed;
  logic               guard;
  logic               sticky;
  logic               inc;
  logic [64:0]        mag;
  logic [64:0]        limit;
  logic               ovf;
  logic [63:0]        sres;
  always_comb begin
    sgn     = op.cvt_src[63];
    exp_eff = (op.cvt_src[62:52] == 11'h000) ? EXP_ONE : op.cvt_src[62:52];
    mant    = {op.cvt_src[62:52] != 11'h000, op.cvt_src[51:0]};
    uexp    = $signed({2'b00, exp_eff}) - EXP_BIAS;
    neg_exp = 13'h0 - uexp;
    is_nan  = (op.cvt_src[62:52] == EXP_ALL_ONES) && (op.cvt_src[51:0] != 52'h0);
    // infinities fall into big; one wide shifter covers both widths
    big     = uexp > E_MAX;
    tiny    = uexp < E_MIN;
    fixed   = 192'h0;
    if (!big && !tiny) begin
      if (!uexp[12]) begin
        fixed = {63'h0, mant, 76'h0} << uexp[5:0];
      end else begin
        fixed = {63'h0, mant, 76'h0} >> neg_exp[6:0];
      end
    end
    guard  = fixed[127];
    sticky = (|fixed[126:0]) || (tiny && (mant != 53'h0));
    case (op.cvt_mode)
      RND_NEAR: inc = guard && (sticky || fixed[128]);
      RND_ZERO: inc = 1'b0;
      RND_PINF: inc = !sgn && (guard || sticky);
      RND_NINF: inc = sgn && (guard || sticky);
      default:  inc = 1'b0;
    endcase
    mag = {1'b0, fixed[191:128]} + {64'h0, inc};
    if (op.cvt_word) begin
      limit = sgn ? W_MAG_NEG : W_MAG_POS;
    end else begin
      limit = sgn ? DW_MAG_NEG : DW_MAG_POS;
    end
    ovf  = is_nan || big || (mag > limit);
    sres = sgn ? (~mag[63:0] + 64'h1) : mag[63:0];
    op.cvt_snan    = is_nan && !op.cvt_src[51];
    op.cvt_invalid = ovf;
    op.cvt_inc     = inc && !ovf;
    op.cvt_inexact = (guard || sticky) && !ovf;
    if (op.cvt_word) begin
      if (ovf) begin
        op.cvt_result = {32'h0, (sgn || is_nan) ? W_NEG_MIN : W_POS_MAX};
      end else begin
        op.cvt_result = {32'h0, sres[31:0]};
      end
    end else if (ovf) begin
      op.cvt_result = (sgn || is_nan) ? DW_NEG_MIN : DW_POS_MAX;
    end else begin
      op.cvt_result = sres;
    end
  end
endmodule

// *** verif/fp_compare_code_seq_model.sv ***
// sequencer model that issues instructions into the compare and convert slice
module fp_compare_code_seq_model (
  // clock
  input  logic             clk_sys,
  // issue towards the slice
  output logic             issue_valid,
  output fp_compare_code_pkg::instr_t instr,
  output fp_compare_code_pkg::dword_t src_a,
  output fp_compare_code_pkg::dword_t src_b
);
  timeunit 1ns;
  timeprecision 100ps;
  import fp_compare_code_pkg::*;
  initial begin
    issue_valid = 1'b0;
    instr = '0;
    src_a = '0;
    src_b = '0;
  end
  // one instruction per edge; stays up until the next send or idle
  task automatic send(input instr_t i, input dword_t a, input dword_t b);
    @(posedge clk_sys);
    #2;
    issue_valid = 1'b1;
    instr = i;
    src_a = a;
    src_b = b;
  endtask
  // released operands are inverted so no stale value looks valid
  task automatic idle();
    @(posedge clk_sys);
    #2;
    issue_valid = 1'b0;
    instr = ~instr;
    src_a = ~src_a;
    src_b = ~src_b;
  endtask
endmodule

// *** verif/fp_compare_convert_unit_test.sv ***
// self-checking bench for the compare and convert slice
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module fp_compare_convert_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  import fp_compare_code_pkg::*;
  typedef struct packed {logic [1:0] kind; dword_t data; logic [4:0] idx; logic [3:0] fl; logic rec; cc_t cr1;} note_t;
  logic   clk_sys, sys_rst, issue_valid, impl_64bit, invalid_enable, inexact_enable, overflow_flag, status_clear;
  instr_t instr;
  dword_t src_a, src_b, target_data;
  rnd_t   round_select;
  logic   result_valid, illegal_instr, target_write, cr_field_write, cr1_write;
  logic   rounding_increment_flag, inexact_flag, inexact_sticky, signaling_nan_invalid;
  logic   invalid_convert_flag, exception_summary, enabled_summary, invalid_summary;
  logic [4:0] target_index;
  logic [2:0] cr_field_index;
  cc_t    cr_field_value, fp_compare_code;
  logic [3:0] cr1_value;
  int     n_errors, n_compared, k;
  logic   cvi_s, snan_s;
  note_t  notes[$];
  note_t  nt;
  dword_t ca [5] = '{64'h3FF0_0000_0000_0000, 64'h4000_0000_0000_0000, 64'h0, 64'h7FF8_0000_0000_0000,
                     64'h3FF0_0000_0000_0000};
  dword_t cb [5] = '{64'h4000_0000_0000_0000, 64'h3FF0_0000_0000_0000, 64'h8000_0000_0000_0000,
                     64'h3FF0_0000_0000_0000, 64'h7FF0_0000_0000_0001};
  cc_t    ce [5] = '{CC_LESS, CC_GREAT, CC_EQUAL, CC_UNORD, CC_UNORD};
  dword_t re [4] = '{64'h2, 64'h2, 64'h3, 64'h2};
  fp_compare_code_seq_model i_seq (.clk_sys(clk_sys), .issue_valid(issue_valid), .instr(instr), .src_a(src_a), .src_b(src_b));
  fp_compare_convert_unit i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .issue_valid(issue_valid), .instr(instr), .src_a(src_a),
    .src_b(src_b), .impl_64bit(impl_64bit), .round_select(round_select), .invalid_enable(invalid_enable),
    .inexact_enable(inexact_enable), .overflow_flag(overflow_flag), .status_clear(status_clear),
    .result_valid(result_valid), .illegal_instr(illegal_instr), .target_write(target_write),
    .target_index(target_index), .target_data(target_data), .cr_field_write(cr_field_write),
    .cr_field_index(cr_field_index), .cr_field_value(cr_field_value), .cr1_write(cr1_write),
    .cr1_value(cr1_value), .fp_compare_code(fp_compare_code), .rounding_increment_flag(rounding_increment_flag),
    .inexact_flag(inexact_flag), .inexact_sticky(inexact_sticky), .signaling_nan_invalid(signaling_nan_invalid),
    .invalid_convert_flag(invalid_convert_flag), .exception_summary(exception_summary),
    .enabled_summary(enabled_summary), .invalid_summary(invalid_summary));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // notes the expected outcome, then issues; stickies accumulate since the last clear
  task automatic op(input logic [1:0] kd, input logic [9:0] xo, input logic [4:0] t, input logic r,
                    input dword_t a, input dword_t b, input rnd_t m, input dword_t e, input logic [3:0] f,
                    input cc_t c1);
    cvi_s = cvi_s | f[1];
    snan_s = snan_s | f[0];
    notes.push_back('{kd, e, t, {f[3:2], cvi_s, snan_s}, r, c1});
    i_seq.send({OPC_PRIMARY, t, RA_ZERO, 5'h00, xo, r}, a, b);
    round_select = m;
  endtask
  task automatic clr();
    i_seq.idle();
    @(posedge clk_sys);
    #2;
    status_clear = 1'b1;
    @(posedge clk_sys);
    #2;
    status_clear = 1'b0;
    cvi_s = 1'b0;
    snan_s = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // result watcher: oldest note against each completed instruction
  always begin
    @(posedge clk_sys);
    #1;
    if (result_valid === 1'b1) begin
      if (notes.size() == 0) begin
        `CHK("spare result", 1'b0, 1'b1)
      end else begin
        nt = notes.pop_front();
        if (nt.kind == 2'd0) begin
          `CHK("field value", nt.data[3:0], cr_field_value)
          `CHK("compare code", nt.data[3:0], fp_compare_code)
          `CHK("field index", nt.idx[4:2], cr_field_index)
          `CHK("snan flag", nt.fl[0], signaling_nan_invalid)
          `CHK("convert flag", nt.fl[1], invalid_convert_flag)
          `CHK("field one strobe", 1'b0, cr1_write)
        end else if (nt.kind == 2'd1) begin
          `CHK("target data", nt.data, target_data)
          `CHK("target index", nt.idx, target_index)
          `CHK("flags", nt.fl, {rounding_increment_flag, inexact_flag, invalid_convert_flag, signaling_nan_invalid})
          `CHK("field one strobe", nt.rec, cr1_write)
          if (nt.rec) `CHK("field one", nt.cr1, cr1_value)
        end else begin
          `CHK("illegal", 1'b1, illegal_instr)
          `CHK("target strobe", 1'b0, target_write)
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    impl_64bit = 1'b1;
    round_select = RND_NEAR;
    invalid_enable = 1'b1;
    inexact_enable = 1'b0;
    overflow_flag = 1'b1;
    status_clear = 1'b0;
    n_errors = 0;
    n_compared = 0;
    cvi_s = 1'b0;
    snan_s = 1'b0;
    k = $urandom(32'h9521c1e7);
    repeat (6) @(posedge clk_sys);
    #2;
    sys_rst = 1'b0;
    clr();
    op(1, XO_CVT_DW, 5'h07, 1, 64'h0, 64'h43F0_0000_0000_0000, RND_NEAR, DW_POS_MAX, 4'h2, 4'hF);
    op(1, XO_CVT_DWZ, 5'h08, 0, 64'h0, 64'hC3F0_0000_0000_0000, RND_PINF, DW_NEG_MIN, 4'h2, 4'h0);
    op(1, XO_CVT_DW, 5'h0C, 0, 64'h0, 64'h7FF0_0000_0000_0000, RND_NEAR, DW_POS_MAX, 4'h2, 4'h0);
    op(1, XO_CVT_DWZ, 5'h0D, 0, 64'h0, 64'hFFF0_0000_0000_0000, RND_NEAR, DW_NEG_MIN, 4'h2, 4'h0);
    op(1, XO_CVT_W, 5'h0E, 0, 64'h0, 64'h7FF0_0000_0000_0000, RND_NEAR, {32'h0, W_POS_MAX}, 4'h2, 4'h0);
    for (int i = 0; i < 5; i++) op(0, XO_CMPU, {i[2:0], 2'b00}, 1, ca[i], cb[i], RND_NEAR, {60'h0, ce[i]},
                                   {3'h0, i == 4}, 4'h0);
    for (int m = 0; m < 4; m++) op(1, XO_CVT_DW, 5'h1F, 0, 64'h0, 64'h4004_0000_0000_0000, rnd_t'(m), re[m],
                                   {m == 2, 3'h4}, 4'h0);
    op(1, XO_CVT_DWZ, 5'h02, 0, 64'h0, 64'h4004_0000_0000_0000, RND_PINF, 64'h2, 4'h4, 4'h0);
    op(1, XO_CVT_W, 5'h03, 0, 64'h0, 64'h4270_0000_0000_0000, RND_NEAR, {32'h0, W_POS_MAX}, 4'h2, 4'h0);
    op(1, XO_CVT_W, 5'h04, 0, 64'h0, 64'hC270_0000_0000_0000, RND_NEAR, {32'h0, W_NEG_MIN}, 4'h2, 4'h0);
    op(1, XO_CVT_W, 5'h05, 0, 64'h0, 64'hBFF8_0000_0000_0000, RND_NEAR, 64'hFFFF_FFFE, 4'hC, 4'h0);
    op(1, XO_CVT_W, 5'h06, 0, 64'h0, 64'h7FF0_0000_0000_0001, RND_NEAR, {32'h0, W_NEG_MIN}, 4'h3, 4'h0);
    op(1, XO_CVT_DW, 5'h09, 0, 64'h0, 64'h7FF8_0000_0000_0000, RND_NEAR, DW_NEG_MIN, 4'h2, 4'h0);
    i_seq.send({OPC_PRIMARY, 5'h03, 5'h01, 5'h00, XO_CVT_DW, 1'b0}, 64'h0, 64'h3FF0_0000_0000_0000);
    i_seq.idle();
    impl_64bit = 1'b0;
    op(2, XO_CVT_DWZ, 5'h0A, 0, 64'h0, 64'h3FF0_0000_0000_0000, RND_NEAR, 64'h0, 4'h0, 4'h0);
    op(1, XO_CVT_W, 5'h0B, 0, 64'h0, 64'h3FF0_0000_0000_0000, RND_NEAR, 64'h1, 4'h0, 4'h0);
    i_seq.idle();
    impl_64bit = 1'b1;
    // random exact integers: no rounding, no flags beyond the stickies
    repeat (8) begin
      k = $urandom_range(0, 1000000);
      op(1, XO_CVT_DW, 5'($urandom), 0, 64'h0, $realtobits(real'(k)), rnd_t'($urandom), 64'(k), 4'h0, 4'h0);
    end
    i_seq.idle();
    for (int w = 0; w < 20 && notes.size() != 0; w++) @(posedge clk_sys);
    `CHK("pending results", 0, notes.size())
    results();
  end
endmodule
